// File: src/timer32_pkg.sv
package timer32_pkg;

	localparam int ADDR_W    = 7;
	localparam int DATA_W    = 32;
	localparam int N_COMPARE = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_INTERRUPT_FLAGS   = 7'h00;
	localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL     = 7'h04;
	localparam logic [ADDR_W-1:0] OFF_MAIN_COUNT        = 7'h08;
	localparam logic [ADDR_W-1:0] OFF_DIVIDER_LIMIT     = 7'h0C;
	localparam logic [ADDR_W-1:0] OFF_DIVIDER_COUNT     = 7'h10;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_ACTION    = 7'h14;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_VALUE_0   = 7'h18;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_VALUE_1   = 7'h1C;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_VALUE_2   = 7'h20;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_VALUE_3   = 7'h24;
	localparam logic [ADDR_W-1:0] OFF_CAPTURE_EDGE      = 7'h28;
	localparam logic [ADDR_W-1:0] OFF_CAPTURE_VALUE_0   = 7'h2C;
	localparam logic [ADDR_W-1:0] OFF_EXTERNAL_OUTPUT   = 7'h3C;
	localparam logic [ADDR_W-1:0] OFF_COUNT_SOURCE      = 7'h70;
	localparam logic [ADDR_W-1:0] OFF_PULSE_WIDTH       = 7'h74;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE        = 7'h78;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR         = 7'h7C;

	// Field layouts
	localparam int FLAGS_W        = 5;
	localparam int FLAG_CAPTURE   = 4;
	localparam int TCR_W          = 2;
	localparam int TCR_ENABLE     = 0;
	localparam int TCR_CLEAR      = 1;
	localparam int CAC_STRIDE     = 3;
	localparam int CAC_W          = 12;
	localparam int CEC_W          = 3;
	localparam int CEC_RISE       = 0;
	localparam int CEC_FALL       = 1;
	localparam int CEC_IRQ        = 2;
	localparam int EOC_W          = 12;
	localparam int EOC_ACTION_LSB = 4;
	localparam int CSC_W          = 3;
	localparam int CSC_SELECT     = 2;
	localparam int PWC_W          = 4;

	// Reset values
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

	// Input synchroniser depth
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {MODE_TIMER, MODE_RISE, MODE_FALL, MODE_BOTH} count_mode_t;
	typedef enum logic [1:0] {EXT_NONE, EXT_CLEAR, EXT_SET, EXT_TOGGLE} ext_action_t;

	typedef struct packed {
		logic stop;
		logic reset;
		logic irq;
	} compare_action_t;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} pin_event_t;

endpackage : timer32_pkg

// File: src/timer32_pin_sync.sv
`timescale 1ns/1ns
module timer32_pin_sync
	import timer32_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clk_en,
	input  wire logic       i_pin,
	output pin_event_t      o_event
);

	if (STAGES < 2)
	begin : g_check
		$error("timer32_pin_sync needs at least two stages");
	end

	logic [STAGES-1:0] chain;
	logic              prev;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			chain <= '0;
			prev  <= 1'b0;
		end
		else if (i_clk_en)
		begin
			chain <= {chain[STAGES-2:0], i_pin};
			prev  <= chain[STAGES-1];
		end
	end

	// Only the last stage feeds the edge logic
	assign o_event.level = chain[STAGES-1];
	assign o_event.rise  = chain[STAGES-1] & ~prev;
	assign o_event.fall  = ~chain[STAGES-1] & prev;

endmodule : timer32_pin_sync

// File: src/timer32_compare_channel.sv
`timescale 1ns/1ns
module timer32_compare_channel
	import timer32_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_clk_en,
	input  wire logic [WIDTH-1:0] i_count,
	input  wire logic [WIDTH-1:0] i_value,
	output logic                  o_match,
	output logic                  o_hit
);

	if (WIDTH < 1)
	begin : g_check
		$error("timer32_compare_channel width must be positive");
	end

	logic match_q;

	assign o_match = (i_count == i_value);
	// One pulse each time the count arrives at the value
	assign o_hit   = o_match & ~match_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			match_q <= 1'b1;
		else if (i_clk_en)
			match_q <= o_match;
	end

endmodule : timer32_compare_channel

// File: src/timer32_match_capture.sv
// Functional notes
// - Interrupt flags show five pending sources; writing ones to the register clears them.
// - Timer control can disable the main counter or hold it in reset.
// - Main counter steps once every divider_limit plus one enabled clocks.
// - At divider count equal to limit, next clock increments main, zeroes divider.
// - Divider count is readable and writable by software, and self-advances.
// - Compare action control picks interrupt and counter reset per compare channel.
// - Compare zero match may reset main counter, stop counters, and/or interrupt.
// - Compare values one to three act like compare zero, independently.
// - Capture edge control picks capture edges and capture interrupt.
// - Selected capture input edge copies main counter into read-only capture value.
// - External output control drives compare function and four external pins.
// - Count source selects timer or counter mode, input and counted edges.
// - Pulse width control switches each external pin into PWM mode.
// - Used bits reset to zero; reserved bits and unused offsets read zero.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Control bit 0 enables counting; bit 1 holds both counters reset.
// - Main counter wraps from all ones to zero without an interrupt.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
module timer32_match_capture
	import timer32_pkg::*;
#(
	parameter int SYNC_DEPTH = SYNC_STAGES
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic              i_capture_in,
	input  wire logic              i_count_in,
	output logic      [DATA_W-1:0] o_rdata,
	output logic                   o_irq,
	output logic   [N_COMPARE-1:0] o_ext_match
);

	if (SYNC_DEPTH < 2)
	begin : g_check
		$error("timer32_match_capture needs SYNC_DEPTH of at least two");
	end

	// Field slicing and the read mux below assume these layouts
	if (CAC_W != N_COMPARE * CAC_STRIDE || FLAGS_W != N_COMPARE + 1 || PWC_W != N_COMPARE
		|| EOC_W != EOC_ACTION_LSB + 2 * N_COMPARE || N_COMPARE != 4)
	begin : g_layout_check
		$error("timer32_match_capture register layout does not fit N_COMPARE");
	end

	// Software visible state
	logic [FLAGS_W-1:0]               interrupt_flags;
	logic [FLAGS_W-1:0]               irq_enable;
	logic [TCR_W-1:0]                 timer_control;
	logic [DATA_W-1:0]                main_count;
	logic [DATA_W-1:0]                divider_limit;
	logic [DATA_W-1:0]                divider_count;
	logic [CAC_W-1:0]                 compare_action_control;
	logic [N_COMPARE-1:0][DATA_W-1:0] compare_value;
	logic [CEC_W-1:0]                 capture_edge_control;
	logic [DATA_W-1:0]                capture_value_zero;
	logic [EOC_W-1:0]                 external_output_control;
	logic [CSC_W-1:0]                 count_source_control;
	logic [PWC_W-1:0]                 pulse_width_control;

	// Next values
	logic [FLAGS_W-1:0]   next_interrupt_flags;
	logic [FLAGS_W-1:0]   next_irq_enable;
	logic [TCR_W-1:0]     next_timer_control;
	logic [DATA_W-1:0]    next_main_count;
	logic [DATA_W-1:0]    next_divider_count;
	logic [DATA_W-1:0]    next_capture_value;
	logic [EOC_W-1:0]     next_external_output;
	logic [N_COMPARE-1:0] next_ext_match;
	logic                 next_irq;
	logic [DATA_W-1:0]    next_rdata;

	// Address decode
	wire wr_flags   = i_wr && (i_addr == OFF_INTERRUPT_FLAGS);
	wire wr_control = i_wr && (i_addr == OFF_TIMER_CONTROL);
	wire wr_main    = i_wr && (i_addr == OFF_MAIN_COUNT);
	wire wr_limit   = i_wr && (i_addr == OFF_DIVIDER_LIMIT);
	wire wr_divider = i_wr && (i_addr == OFF_DIVIDER_COUNT);
	wire wr_action  = i_wr && (i_addr == OFF_COMPARE_ACTION);
	wire wr_cap_ctl = i_wr && (i_addr == OFF_CAPTURE_EDGE);
	wire wr_ext     = i_wr && (i_addr == OFF_EXTERNAL_OUTPUT);
	wire wr_source  = i_wr && (i_addr == OFF_COUNT_SOURCE);
	wire wr_pwm     = i_wr && (i_addr == OFF_PULSE_WIDTH);
	wire wr_irq_en  = i_wr && (i_addr == OFF_IRQ_ENABLE);
	wire wr_irq_clr = i_wr && (i_addr == OFF_IRQ_CLEAR);

	logic [N_COMPARE-1:0] wr_compare;
	assign wr_compare[0] = i_wr && (i_addr == OFF_COMPARE_VALUE_0);
	assign wr_compare[1] = i_wr && (i_addr == OFF_COMPARE_VALUE_1);
	assign wr_compare[2] = i_wr && (i_addr == OFF_COMPARE_VALUE_2);
	assign wr_compare[3] = i_wr && (i_addr == OFF_COMPARE_VALUE_3);

	// Pin synchronisers
	pin_event_t capture_pin;
	pin_event_t count_pin;

	timer32_pin_sync #(
		.STAGES (SYNC_DEPTH)
	) u_capture_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_capture_in),
		.o_event   (capture_pin)
	);

	timer32_pin_sync #(
		.STAGES (SYNC_DEPTH)
	) u_count_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_count_in),
		.o_event   (count_pin)
	);

	// Compare channels
	logic [N_COMPARE-1:0] match;
	logic [N_COMPARE-1:0] hit;
	logic [N_COMPARE-1:0] act_irq;
	logic [N_COMPARE-1:0] act_reset;
	logic [N_COMPARE-1:0] act_stop;
	logic [N_COMPARE-1:0] ext_state;
	logic [N_COMPARE-1:0] pin_level;

	// A same-cycle write is the base that a match action works on
	wire [EOC_W-1:0] ext_written = wr_ext ? i_wdata[EOC_W-1:0] : external_output_control;

	for (genvar k = 0; k < N_COMPARE; k++)
	begin : g_compare
		compare_action_t act;
		ext_action_t     ext_act;

		assign act          = compare_action_control[k*CAC_STRIDE +: CAC_STRIDE];
		assign act_irq[k]   = act.irq;
		assign act_reset[k] = act.reset;
		assign act_stop[k]  = act.stop;

		timer32_compare_channel #(
			.WIDTH (DATA_W)
		) u_channel (
			.i_ref_clk (i_ref_clk),
			.i_rst_n   (i_rst_n),
			.i_clk_en  (i_clk_en),
			.i_count   (main_count),
			.i_value   (compare_value[k]),
			.o_match   (match[k]),
			.o_hit     (hit[k])
		);

		assign ext_act      = ext_action_t'(ext_written[EOC_ACTION_LSB + 2*k +: 2]);
		assign ext_state[k] = !hit[k] ? ext_written[k] :
			(ext_act == EXT_SET) ? 1'b1 :
			(ext_act == EXT_CLEAR) ? 1'b0 :
			(ext_act == EXT_TOGGLE) ? ~ext_written[k] : ext_written[k];

		assign pin_level[k] = pulse_width_control[k] ? (main_count >= compare_value[k]) :
			external_output_control[k];
	end

	// Pin states change on a hit; the action bits pass through unchanged
	assign next_external_output = {ext_written[EOC_W-1:N_COMPARE], ext_state};
	assign next_ext_match       = pin_level;

	count_mode_t count_mode;
	pin_event_t  source_pin;
	assign count_mode = count_mode_t'(count_source_control[1:0]);
	assign source_pin = count_source_control[CSC_SELECT] ? count_pin : capture_pin;

	wire source_edge = (count_mode == MODE_RISE) ? source_pin.rise :
		(count_mode == MODE_FALL) ? source_pin.fall :
		(source_pin.rise | source_pin.fall);
	// Counter mode edges pace the divider as clocks do in timer mode
	wire count_event = (count_mode == MODE_TIMER) ? 1'b1 : source_edge;

	wire counters_held = timer_control[TCR_CLEAR];
	wire run           = timer_control[TCR_ENABLE] & ~counters_held;

	// Stop acts only while running, so a restart sitting on the match stops again
	// Match-driven stop and reset
	wire stop_now  = run & |(match & act_stop);
	wire reset_now = |(match & act_reset);
	wire step      = run & count_event & ~stop_now;
	wire div_term  = (divider_count == divider_limit);
	wire main_tick = step & div_term;

	wire [TCR_W-1:0] control_written = wr_control ? i_wdata[TCR_W-1:0] : timer_control;
	assign next_timer_control = stop_now ?
		(control_written & ~(TCR_W'(1) << TCR_ENABLE)) : control_written;

	// Held clear beats bus writes, and bus writes beat stepping
	// Divider count: bus writable, self advancing
	assign next_divider_count = counters_held ? RESET_WORD :
		wr_divider ? i_wdata :
		(stop_now & reset_now) ? RESET_WORD :
		!step ? divider_count :
		div_term ? RESET_WORD : divider_count + 32'h0000_0001;

	// Main count steps at divider terminal count
	// Plain wrap past all ones, no flag
	assign next_main_count = counters_held ? RESET_WORD :
		wr_main ? i_wdata :
		(stop_now & reset_now) ? RESET_WORD :
		!main_tick ? main_count :
		reset_now ? RESET_WORD : main_count + 32'h0000_0001;

	wire capture_event = (capture_edge_control[CEC_RISE] & capture_pin.rise) |
		(capture_edge_control[CEC_FALL] & capture_pin.fall);
	wire capture_irq   = capture_event & capture_edge_control[CEC_IRQ];

	assign next_capture_value = capture_event ? main_count : capture_value_zero;

	// Flag set and clear, set wins
	wire [FLAGS_W-1:0] flag_set = {capture_irq, hit & act_irq};
	wire [FLAGS_W-1:0] flag_clr = (wr_flags | wr_irq_clr) ? i_wdata[FLAGS_W-1:0] : '0;
	assign next_interrupt_flags = (interrupt_flags & ~flag_clr) | flag_set;
	assign next_irq_enable      = wr_irq_en ? i_wdata[FLAGS_W-1:0] : irq_enable;

	// Level interrupt follows the flags as they land
	assign next_irq = |(next_interrupt_flags & next_irq_enable);

	// Read data stand one cycle; idle cycles and write-only offsets give zero
	// Unused bits and offsets read zero
	assign next_rdata = !i_rd ? RESET_WORD :
		(i_addr == OFF_INTERRUPT_FLAGS) ? DATA_W'(interrupt_flags) :
		(i_addr == OFF_TIMER_CONTROL)   ? DATA_W'(timer_control) :
		(i_addr == OFF_MAIN_COUNT)      ? main_count :
		(i_addr == OFF_DIVIDER_LIMIT)   ? divider_limit :
		(i_addr == OFF_DIVIDER_COUNT)   ? divider_count :
		(i_addr == OFF_COMPARE_ACTION)  ? DATA_W'(compare_action_control) :
		(i_addr == OFF_COMPARE_VALUE_0) ? compare_value[0] :
		(i_addr == OFF_COMPARE_VALUE_1) ? compare_value[1] :
		(i_addr == OFF_COMPARE_VALUE_2) ? compare_value[2] :
		(i_addr == OFF_COMPARE_VALUE_3) ? compare_value[3] :
		(i_addr == OFF_CAPTURE_EDGE)    ? DATA_W'(capture_edge_control) :
		(i_addr == OFF_CAPTURE_VALUE_0) ? capture_value_zero :
		(i_addr == OFF_EXTERNAL_OUTPUT) ? DATA_W'(external_output_control) :
		(i_addr == OFF_COUNT_SOURCE)    ? DATA_W'(count_source_control) :
		(i_addr == OFF_PULSE_WIDTH)     ? DATA_W'(pulse_width_control) :
		(i_addr == OFF_IRQ_ENABLE)      ? DATA_W'(irq_enable) :
		RESET_WORD;

	// Counters, flags and status on the one clock
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			timer_control      <= '0;
			main_count         <= RESET_WORD;
			divider_count      <= RESET_WORD;
			capture_value_zero <= RESET_WORD;
			interrupt_flags    <= '0;
			irq_enable         <= '0;
		end
		else if (i_clk_en)
		begin
			timer_control      <= next_timer_control;
			main_count         <= next_main_count;
			divider_count      <= next_divider_count;
			capture_value_zero <= next_capture_value;
			interrupt_flags    <= next_interrupt_flags;
			irq_enable         <= next_irq_enable;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			divider_limit           <= RESET_WORD;
			compare_action_control  <= '0;
			capture_edge_control    <= '0;
			count_source_control    <= '0;
			pulse_width_control     <= '0;
			external_output_control <= '0;
		end
		else if (i_clk_en)
		begin
			if (wr_limit)
				divider_limit <= i_wdata;
			if (wr_action)
				compare_action_control <= i_wdata[CAC_W-1:0];
			if (wr_cap_ctl)
				capture_edge_control <= i_wdata[CEC_W-1:0];
			if (wr_source)
				count_source_control <= i_wdata[CSC_W-1:0];
			if (wr_pwm)
				pulse_width_control <= i_wdata[PWC_W-1:0];
			external_output_control <= next_external_output;
		end
	end

	// Compare values
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			compare_value <= '0;
		else if (i_clk_en)
		begin
			for (int k = 0; k < N_COMPARE; k++)
			begin
				if (wr_compare[k])
					compare_value[k] <= i_wdata;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata     <= RESET_WORD;
			o_irq       <= 1'b0;
			o_ext_match <= '0;
		end
		else if (i_clk_en)
		begin
			o_rdata     <= next_rdata;
			o_irq       <= next_irq;
			o_ext_match <= next_ext_match;
		end
	end

endmodule : timer32_match_capture

// File: verification/timer32_match_capture_asserts.sv
`timescale 1ns/1ns
module timer32_match_capture_asserts
	import timer32_pkg::*;
#(
	parameter int SYNC_DEPTH = SYNC_STAGES
) (
	input wire logic                 i_ref_clk,
	input wire logic                 i_rst_n,
	input wire logic                 i_clk_en,
	input wire logic [ADDR_W-1:0]    i_addr,
	input wire logic [DATA_W-1:0]    i_wdata,
	input wire logic                 i_wr,
	input wire logic                 i_rd,
	input wire logic                 i_capture_in,
	input wire logic                 i_count_in,
	input wire logic [DATA_W-1:0]    o_rdata,
	input wire logic                 o_irq,
	input wire logic [N_COMPARE-1:0] o_ext_match
);
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_rdata_idle: assert property ($past(i_clk_en) && !$past(i_rd) |-> o_rdata == '0)
		else $error("read data not zero outside a read answer");
	a_flags_reserved: assert property ($past(i_clk_en && i_rd && i_addr == OFF_INTERRUPT_FLAGS) |-> o_rdata[DATA_W-1:FLAGS_W] == '0)
		else $error("flag read shows upper bits");
	a_unmapped_zero: assert property ($past(i_clk_en && i_rd && i_addr >= 7'h40 && i_addr <= 7'h6C) |-> o_rdata == '0)
		else $error("unused offset read not zero");
	a_control_width: assert property ($past(i_clk_en && i_rd && i_addr == OFF_TIMER_CONTROL) |-> o_rdata[DATA_W-1:TCR_W] == '0)
		else $error("control read shows upper bits");
	a_mask_drops_irq: assert property (i_clk_en && i_wr && i_addr == OFF_IRQ_ENABLE && i_wdata[FLAGS_W-1:0] == '0
		##1 i_clk_en && !(i_wr && i_addr == OFF_IRQ_ENABLE) |=> !o_irq)
		else $error("interrupt stays high with all sources masked");
	a_limit_readback: assert property (i_clk_en && i_wr && i_addr == OFF_DIVIDER_LIMIT
		##1 i_clk_en && i_rd && i_addr == OFF_DIVIDER_LIMIT |=> o_rdata == $past(i_wdata, 2))
		else $error("divider limit readback differs");
	a_compare_readback: assert property (i_clk_en && i_wr && i_addr == OFF_COMPARE_VALUE_3
		##1 i_clk_en && i_rd && i_addr == OFF_COMPARE_VALUE_3 |=> o_rdata == $past(i_wdata, 2))
		else $error("compare value readback differs");
	a_clear_holds: assert property (i_clk_en && i_wr && i_addr == OFF_TIMER_CONTROL && i_wdata[TCR_CLEAR]
		##1 i_clk_en ##1 i_clk_en && i_rd && i_addr == OFF_MAIN_COUNT |=> o_rdata == '0)
		else $error("main count not cleared");
	a_irq_clear_reads: assert property ($past(i_clk_en && i_rd && i_addr == OFF_IRQ_CLEAR) |-> o_rdata == '0)
		else $error("clear register read not zero");
endmodule : timer32_match_capture_asserts

bind timer32_match_capture timer32_match_capture_asserts #(.SYNC_DEPTH(SYNC_DEPTH)) timer32_match_capture_asserts_inst (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.i_capture_in(i_capture_in),
	.i_count_in(i_count_in),
	.o_rdata(o_rdata),
	.o_irq(o_irq),
	.o_ext_match(o_ext_match)
);

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench
	import timer32_pkg::*;
;
	typedef struct {
		logic [1:0]        sel;
		logic [DATA_W-1:0] val;
	} note_t;
	logic                 i_ref_clk = 1'b0;
	logic                 i_rst_n = 1'b0;
	logic                 i_clk_en = 1'b1;
	logic [ADDR_W-1:0]    i_addr = '0;
	logic [DATA_W-1:0]    i_wdata = '0;
	logic                 i_wr = 1'b0;
	logic                 i_rd = 1'b0;
	logic                 i_capture_in = 1'b0;
	logic                 i_count_in = 1'b0;
	logic [DATA_W-1:0]    o_rdata;
	logic                 o_irq;
	logic [N_COMPARE-1:0] o_ext_match;
	note_t                notes[$];
	note_t                note;
	logic                 rd_seen = 1'b0;
	int                   mismatches = 0;
	int                   comparisons = 0;
	int                   cycles = 0;
	int                   seed = 32'h1454;
	logic [DATA_W-1:0]    rnd;
	logic [ADDR_W-1:0]    all_offs [20] = '{7'h00, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h1C, 7'h20, 7'h24,
		7'h28, 7'h2C, 7'h3C, 7'h70, 7'h74, 7'h78, 7'h7C, 7'h40, 7'h6C, 7'h05};
	logic [ADDR_W-1:0]    rw_offs [11] = '{7'h08, 7'h0C, 7'h10, 7'h18, 7'h1C, 7'h20, 7'h24, 7'h14, 7'h28, 7'h3C, 7'h74};
	int                   rw_w [11] = '{32, 32, 32, 32, 32, 32, 32, CAC_W, CEC_W, EOC_W, PWC_W};

	timer32_match_capture timer32_match_capture_inst (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_capture_in(i_capture_in),
		.i_count_in(i_count_in),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_ext_match(o_ext_match)
	);

	initial
	begin
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [DATA_W-1:0] wmask(input int w);
		return DATA_W'((64'h1 << w) - 64'h1);
	endfunction : wmask

	// Every bus step lasts exactly one clock
	task automatic bus(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		i_wr    <= w;
		i_rd    <= r;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		notes.push_back('{2'd0, e});
		bus(1'b0, 1'b1, a, '0);
	endtask : rd

	task automatic idle(input int n);
		bus(1'b0, 1'b0, i_addr, '0);
		repeat (n - 1) @(posedge i_ref_clk);
	endtask : idle

	// Output levels are noted now and compared at the next falling edge
	task automatic look(input logic [1:0] s, input logic [DATA_W-1:0] e);
		notes.push_back('{s, e});
	endtask : look

	task automatic take();
		note = notes.pop_front();
		chk((note.sel == 2'd1) ? DATA_W'(o_irq) : (note.sel == 2'd2) ? DATA_W'(o_ext_match) : o_rdata, note.val);
	endtask : take

	task automatic restart();
		wr(OFF_TIMER_CONTROL, 32'h2);
		wr(OFF_TIMER_CONTROL, 32'h1);
	endtask : restart

	always @(posedge i_ref_clk)
	begin
		rd_seen <= i_rd && i_clk_en;
		cycles++;
		if (cycles == 6000)
		begin
			mismatches++;
			close_out();
		end
	end

	// Results are compared mid-cycle, oldest note first
	always @(negedge i_ref_clk)
	begin
		if (rd_seen)
			take();
		while (notes.size() > 0 && notes[0].sel != 2'd0)
			take();
	end

	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		foreach (all_offs[j]) rd(all_offs[j], '0);
		foreach (rw_offs[j])
		begin
			rnd = $random(seed);
			wr(rw_offs[j], rnd);
			rd(rw_offs[j], rnd & wmask(rw_w[j]));
		end
		wr(OFF_CAPTURE_VALUE_0, rnd);
		rd(OFF_CAPTURE_VALUE_0, '0);
		foreach (rw_offs[j]) wr(rw_offs[j], '0);
		wr(OFF_IRQ_CLEAR, 32'h1F);
		wr(OFF_MAIN_COUNT, 32'h0000_00A5);
		wr(OFF_DIVIDER_COUNT, 32'h1);
		wr(OFF_TIMER_CONTROL, 32'h2);
		wr(OFF_TIMER_CONTROL, 32'h0);
		rd(OFF_MAIN_COUNT, '0);
		rd(OFF_DIVIDER_COUNT, '0);
		wr(OFF_DIVIDER_LIMIT, 32'h2);
		wr(OFF_TIMER_CONTROL, 32'h1);
		i_clk_en <= 1'b0;
		idle(5);
		i_clk_en <= 1'b1;
		idle(10);
		wr(OFF_TIMER_CONTROL, 32'h0);
		rd(OFF_MAIN_COUNT, 32'h3);
		rd(OFF_DIVIDER_COUNT, 32'h2);
		wr(OFF_MAIN_COUNT, 32'hFFFF_FFFE);
		wr(OFF_DIVIDER_LIMIT, '0);
		wr(OFF_DIVIDER_COUNT, '0);
		wr(OFF_TIMER_CONTROL, 32'h1);
		idle(1);
		wr(OFF_TIMER_CONTROL, 32'h0);
		rd(OFF_MAIN_COUNT, '0);
		rd(OFF_INTERRUPT_FLAGS, '0);
		for (int k = 0; k < N_COMPARE; k++)
		begin
			for (int c = 0; c < N_COMPARE; c++) wr(ADDR_W'(OFF_COMPARE_VALUE_0 + 4 * c), (c == k) ? 32'h5 : 32'h1000);
			wr(OFF_COMPARE_ACTION, 32'h1 << (CAC_STRIDE * k));
			wr(OFF_EXTERNAL_OUTPUT, 32'h3 << (EOC_ACTION_LSB + 2 * k));
			wr(OFF_IRQ_ENABLE, 32'h1 << k);
			restart();
			idle(12);
			wr(OFF_TIMER_CONTROL, 32'h0);
			idle(3);
			look(2'd1, 32'h1);
			look(2'd2, 32'h1 << k);
			rd(OFF_INTERRUPT_FLAGS, 32'h1 << k);
			wr(OFF_INTERRUPT_FLAGS, '0);
			rd(OFF_INTERRUPT_FLAGS, 32'h1 << k);
			wr(OFF_IRQ_ENABLE, '0);
			idle(3);
			look(2'd1, '0);
			wr(OFF_INTERRUPT_FLAGS, 32'h1 << k);
			rd(OFF_INTERRUPT_FLAGS, '0);
		end
		wr(OFF_COMPARE_ACTION, 32'h5);
		wr(OFF_COMPARE_VALUE_0, 32'h5);
		restart();
		idle(12);
		rd(OFF_MAIN_COUNT, 32'h5);
		rd(OFF_TIMER_CONTROL, '0);
		wr(OFF_COMPARE_ACTION, 32'h2);
		wr(OFF_COMPARE_VALUE_0, 32'h3);
		restart();
		idle(10);
		wr(OFF_TIMER_CONTROL, 32'h0);
		rd(OFF_MAIN_COUNT, 32'h3);
		wr(OFF_IRQ_CLEAR, 32'h1F);
		wr(OFF_CAPTURE_EDGE, 32'h5);
		wr(OFF_IRQ_ENABLE, 32'h10);
		rnd = $random(seed);
		wr(OFF_MAIN_COUNT, rnd);
		i_capture_in <= 1'b1;
		idle(6);
		rd(OFF_CAPTURE_VALUE_0, rnd);
		rd(OFF_INTERRUPT_FLAGS, 32'h10);
		look(2'd1, 32'h1);
		wr(OFF_MAIN_COUNT, 32'h7);
		i_capture_in <= 1'b0;
		idle(6);
		rd(OFF_CAPTURE_VALUE_0, rnd);
		wr(OFF_COMPARE_ACTION, '0);
		for (int m = 1; m < 4; m++)
		begin
			wr(OFF_COUNT_SOURCE, 32'h4 | m);
			restart();
			repeat (3)
			begin
				i_count_in <= 1'b1;
				idle(4);
				i_count_in <= 1'b0;
				idle(4);
			end
			wr(OFF_TIMER_CONTROL, 32'h0);
			rd(OFF_MAIN_COUNT, (m == 3) ? 32'h6 : 32'h3);
		end
		wr(OFF_COUNT_SOURCE, '0);
		wr(OFF_EXTERNAL_OUTPUT, '0);
		wr(OFF_COMPARE_VALUE_2, 32'h4);
		wr(OFF_PULSE_WIDTH, 32'h4);
		wr(OFF_MAIN_COUNT, 32'h7);
		idle(3);
		look(2'd2, 32'h4);
		wr(OFF_MAIN_COUNT, 32'h2);
		idle(3);
		look(2'd2, '0);
		idle(2);
		close_out();
	end
endmodule : testbench
